// ### shared/uart_cfg.svh
/*
  Register indices, field positions, reset values and bit-time counts of the serial port.
  Assumes an AHB-Lite word bus where byte address = 4 * register index.
*/
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
// ==========
// Register indices
`define IDX_PWR 8'h87
`define IDX_CTRL 8'h98
`define IDX_DATA 8'h99
`define IDX_SLV_ADDR 8'hA9
`define IDX_SLV_MASK 8'hB9
`define IDX_BAUD 8'hC0
`define IDX_ISTAT 8'hC1
`define IDX_IMASK 8'hC2
// ==========
// Field positions
`define CTL_TOP 7
`define CTL_MODE1 6
`define CTL_MATCH 5
`define CTL_REN 4
`define CTL_TX9 3
`define CTL_RX9 2
`define CTL_TXF 1
`define CTL_RXF 0
`define PWR_DBL 7
`define PWR_FES 6
// ==========
// Reset values and counts
`define RST_BYTE 8'h00
`define RST_BAUD 16'h0064
`define PER_M0 16'h0006
`define PER_M2 16'h0020
`define PER_M2D 16'h0010
`define LAST8 4'h7
`define LAST9 4'h8
`define HSIZE_WORD 3'h2
`endif

// ### shared/uart_pkg.sv
/*
  Types of the serial port: operating modes and state machine states.
  Assumes nothing of its surroundings.
*/
package uart_pkg;
  typedef enum logic [1:0] {MODE_SHIFT, MODE_8V, MODE_9F, MODE_9V} mode_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_SHIFT} rx_state_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_SHIFT} tx_state_t;
endpackage : uart_pkg

// ### shared/tx_if.sv
/*
  Channel between the register block and the transmit engine.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface tx_if;
  logic start;
  logic [7:0] data;
  logic ninth;
  uart_pkg::mode_t mode;
  logic [15:0] period;
  logic done;
  logic line;
  logic dout;
  logic doe_n;
  logic busy;
  modport ctrl (output start, data, ninth, mode, period,
                input done, line, dout, doe_n, busy);
  modport eng (input start, data, ninth, mode, period,
               output done, line, dout, doe_n, busy);
endinterface : tx_if

// ### design/addr_match.sv
/*
  Address recognition: compares a received byte with the given and broadcast addresses.
  Assumes the slave address and mask come from registers on the same clock.
*/
`timescale 1ns/1ps
module addr_match (
  input wire logic [7:0] rx_byte,
  input wire logic [7:0] addr,
  input wire logic [7:0] mask,
  output logic match
);
  wire [7:0] given = addr & mask;
  wire [7:0] bcast = addr | mask;
  // Mask zeros are ignored positions
  wire hit_given = ((rx_byte ^ given) & mask) == 8'h00;
  // Broadcast ones must be received as ones
  wire hit_bcast = (~rx_byte & bcast) == 8'h00;
  assign match = hit_given | hit_bcast;
endmodule : addr_match

// ### design/uart_tx.sv
/*
  Transmit engine: start, 8 or 9 data bits, stop; or 8-bit shift output with clock.
  Assumes period of at least two clocks and a start pulse only while idle.
*/
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_tx (
  input wire logic hclk,
  input wire logic hresetn,
  tx_if.eng tx
);
  uart_pkg::tx_state_t state, next_state;
  logic [15:0] cnt, next_cnt;
  logic [3:0] bitn, next_bit;
  logic [8:0] sh, next_sh;
  logic next_line, next_dout, next_doe_n, next_done;

  wire tick = cnt == 16'h0000;
  wire m0 = tx.mode == uart_pkg::MODE_SHIFT;
  wire nine = tx.mode == uart_pkg::MODE_9F || tx.mode == uart_pkg::MODE_9V;
  wire [3:0] last = nine ? `LAST9 : `LAST8;
  wire [15:0] half = tx.period >> 1;
  assign tx.busy = state != uart_pkg::TX_IDLE;

  // ==========
  // Next state
  always_comb begin
    next_state = state;
    next_cnt = tick ? tx.period - 16'h0001 : cnt - 16'h0001;
    next_bit = bitn;
    next_sh = sh;
    next_done = 1'b0;
    next_line = 1'b1;
    next_dout = 1'b1;
    next_doe_n = 1'b1;
    unique case (state)
      uart_pkg::TX_IDLE: begin
        next_cnt = tx.period - 16'h0001;
        if (tx.start) begin
          next_sh = {tx.ninth, tx.data};
          next_bit = 4'h0;
          next_state = m0 ? uart_pkg::TX_SHIFT : uart_pkg::TX_START;
        end
      end
      uart_pkg::TX_START: begin
        next_line = 1'b0;
        if (tick) next_state = uart_pkg::TX_DATA;
      end
      uart_pkg::TX_DATA: begin
        next_line = sh[0];
        if (tick) begin
          next_sh = {1'b0, sh[8:1]};
          next_bit = bitn + 4'h1;
          if (bitn == last) begin
            next_state = uart_pkg::TX_STOP;
            next_done = 1'b1;
          end
        end
      end
      uart_pkg::TX_STOP: begin
        if (tick) next_state = uart_pkg::TX_IDLE;
      end
      uart_pkg::TX_SHIFT: begin
        next_doe_n = 1'b0;
        next_dout = sh[0];
        next_line = cnt < half;
        if (tick) begin
          next_sh = {1'b0, sh[8:1]};
          next_bit = bitn + 4'h1;
          if (bitn == `LAST8) begin
            next_state = uart_pkg::TX_IDLE;
            next_done = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= uart_pkg::TX_IDLE;
      cnt <= 16'h0000;
      bitn <= 4'h0;
      sh <= 9'h000;
      tx.line <= 1'b1;
      tx.dout <= 1'b1;
      tx.doe_n <= 1'b1;
      tx.done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bitn <= next_bit;
      sh <= next_sh;
      tx.line <= next_line;
      tx.dout <= next_dout;
      tx.doe_n <= next_doe_n;
      tx.done <= next_done;
    end
  end
endmodule : uart_tx

// ### design/uart_frame_check_addr_match.sv
/*
  Serial port with framing error check and address recognition, AHB-Lite register slave.
  Assumes one clock, word-only accesses, baud register of at least two clocks.
*/
// Register access over AHB-Lite is this design's own decision.
// Contract
// - Missing stop bit sets frame error flag
// - Control bit 7 is flag or mode bit
// - Frame error flag sticky, cleared by software
// - Address filtering only while match enable set
// - Nine-bit modes: ninth bit one and match
// - Eight-bit mode: valid stop and match
// - Shift mode ignores match enable
// - Ninth bit or stop bit captured
// - Transmit done at stop or eighth bit
// - Receive done mid stop or eighth bit
// - Given address is address AND mask
// - Broadcast is address OR mask
// - Address and mask reset to zero
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_frame_check_addr_match (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe_n,
  output logic txd,
  output logic irq
);
  // ==========
  // Bus slave
  logic wr_pend, rd_pend;
  logic [7:0] idx;
  wire ap = hsel & htrans[1] & hready;
  wire [7:0] wd = hwdata[7:0];
  wire wr_ctrl = wr_pend && idx == `IDX_CTRL;
  wire wr_pwr = wr_pend && idx == `IDX_PWR;
  wire wr_data = wr_pend && idx == `IDX_DATA;
  wire wr_slv_addr = wr_pend && idx == `IDX_SLV_ADDR;
  wire wr_slv_mask = wr_pend && idx == `IDX_SLV_MASK;
  wire wr_baud = wr_pend && idx == `IDX_BAUD;
  wire wr_istat = wr_pend && idx == `IDX_ISTAT;
  wire wr_imask = wr_pend && idx == `IDX_IMASK;

  // Reads wait one cycle so a preceding write is visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      idx <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= ap & hwrite & (hsize == `HSIZE_WORD);
      rd_pend <= ap & ~hwrite;
      if (ap) idx <= haddr[9:2];
      hreadyout <= ~(ap & ~hwrite);
      hresp <= 1'b0;
    end
  end

  // ==========
  // Registers
  logic mode_bit0, frame_err, fes, dbl;
  logic [6:0] ctl;
  logic [7:0] slv_addr, slv_mask, rx_buf;
  logic [15:0] baud;
  logic [2:0] istat, imask;

  wire rx_flag = ctl[`CTL_RXF];
  wire tx_flag = ctl[`CTL_TXF];
  wire rx_bit9 = ctl[`CTL_RX9];
  wire tx_bit9 = ctl[`CTL_TX9];
  wire ren = ctl[`CTL_REN];
  wire match_en = ctl[`CTL_MATCH];
  wire uart_pkg::mode_t mode = uart_pkg::mode_t'({mode_bit0, ctl[`CTL_MODE1]});
  wire m0 = mode == uart_pkg::MODE_SHIFT;
  wire m8 = mode == uart_pkg::MODE_8V;
  wire nine = mode == uart_pkg::MODE_9F || mode == uart_pkg::MODE_9V;
  wire top_bit = fes ? frame_err : mode_bit0;
  wire [7:0] ctl_rd = {top_bit, ctl};
  wire [7:0] pwr_rd = {dbl, fes, 6'h00};

  wire [31:0] rd_mux =
    idx == `IDX_CTRL ? {24'h000000, ctl_rd} :
    idx == `IDX_PWR ? {24'h000000, pwr_rd} :
    idx == `IDX_DATA ? {24'h000000, rx_buf} :
    idx == `IDX_SLV_ADDR ? {24'h000000, slv_addr} :
    idx == `IDX_SLV_MASK ? {24'h000000, slv_mask} :
    idx == `IDX_BAUD ? {16'h0000, baud} :
    idx == `IDX_ISTAT ? {29'h00000000, istat} :
    idx == `IDX_IMASK ? {29'h00000000, imask} : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h00000000;
    else if (rd_pend) hrdata <= rd_mux;
  end

  // ==========
  // Bit timing
  wire [15:0] per = m0 ? `PER_M0 :
                    mode == uart_pkg::MODE_9F ? (dbl ? `PER_M2D : `PER_M2) : baud;
  wire [15:0] half = per >> 1;

  // ==========
  // Receive pin synchroniser
  logic rxd_s1, rxd_s2, rxd_d;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      rxd_d <= 1'b1;
    end else begin
      rxd_s1 <= rxd_in;
      rxd_s2 <= rxd_s1;
      rxd_d <= rxd_s2;
    end
  end

  // ==========
  // Receiver
  uart_pkg::rx_state_t rx_state, next_state;
  logic [15:0] rx_cnt, next_cnt;
  logic [3:0] rx_bit, next_bit;
  logic [8:0] rx_sh, next_sh;
  logic rx_stop, next_stop, rx_fin, next_fin;
  logic match;

  wire rx_tick = rx_cnt == 16'h0000;
  wire [3:0] rx_last = nine ? `LAST9 : `LAST8;
  wire [7:0] rx_byte = nine ? rx_sh[7:0] : rx_sh[8:1];
  wire rx_ninth = rx_sh[8];
  wire rx_sclk = rx_cnt < half;

  always_comb begin
    next_state = rx_state;
    next_cnt = rx_tick ? per - 16'h0001 : rx_cnt - 16'h0001;
    next_bit = rx_bit;
    next_sh = rx_sh;
    next_stop = rx_stop;
    next_fin = 1'b0;
    unique case (rx_state)
      uart_pkg::RX_IDLE: begin
        next_cnt = per - 16'h0001;
        next_bit = 4'h0;
        if (m0 && !rx_flag) begin
          next_state = uart_pkg::RX_SHIFT;
        end else if (!m0 && rxd_d && !rxd_s2) begin
          // Check the start bit at its middle
          next_state = uart_pkg::RX_START;
          next_cnt = half - 16'h0001;
        end
      end
      uart_pkg::RX_START: begin
        if (rx_tick) next_state = rxd_s2 ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
      end
      uart_pkg::RX_DATA, uart_pkg::RX_SHIFT: begin
        if (rx_tick) begin
          next_sh = {rxd_s2, rx_sh[8:1]};
          next_bit = rx_bit + 4'h1;
          if (rx_bit == rx_last) begin
            next_fin = rx_state == uart_pkg::RX_SHIFT;
            next_state = next_fin ? uart_pkg::RX_IDLE : uart_pkg::RX_STOP;
          end
        end
      end
      uart_pkg::RX_STOP: begin
        // Stop bit sampled halfway through
        if (rx_tick) begin
          next_stop = rxd_s2;
          next_fin = 1'b1;
          next_state = uart_pkg::RX_IDLE;
        end
      end
    endcase
    if (!ren) begin
      next_state = uart_pkg::RX_IDLE;
      next_fin = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state <= uart_pkg::RX_IDLE;
      rx_cnt <= 16'h0000;
      rx_bit <= 4'h0;
      rx_sh <= 9'h000;
      rx_stop <= 1'b1;
      rx_fin <= 1'b0;
    end else begin
      rx_state <= next_state;
      rx_cnt <= next_cnt;
      rx_bit <= next_bit;
      rx_sh <= next_sh;
      rx_stop <= next_stop;
      rx_fin <= next_fin;
    end
  end

  addr_match u_match (
    .rx_byte(rx_byte),
    .addr(slv_addr),
    .mask(slv_mask),
    .match(match)
  );

  // ==========
  // Frame completion
  wire ok_addr = (m8 ? rx_stop : rx_ninth) && match;
  wire set_rx_flag = rx_fin && (m0 || !match_en || ok_addr);
  wire set_frame_err = rx_fin && !m0 && !rx_stop;
  wire rx_bit9_val = m8 ? rx_stop : rx_ninth;
  wire ld_rx_bit9 = set_rx_flag && !m0;

  // ==========
  // Transmit engine
  tx_if txc ();
  assign txc.start = wr_data;
  assign txc.data = wd;
  assign txc.ninth = tx_bit9;
  assign txc.mode = mode;
  assign txc.period = per;
  wire tx_done = txc.done;

  uart_tx u_tx (
    .hclk(hclk),
    .hresetn(hresetn),
    .tx(txc.eng)
  );

  // ==========
  // Control register update, hardware set wins over software clear
  wire [6:0] ctl_w = wr_ctrl ? wd[6:0] : ctl;
  wire next_rx_bit9 = ld_rx_bit9 ? rx_bit9_val : ctl_w[`CTL_RX9];
  wire next_tx_flag = tx_done | ctl_w[`CTL_TXF];
  wire next_rx_flag = set_rx_flag | ctl_w[`CTL_RXF];
  wire [2:0] ev = {set_frame_err, set_rx_flag, tx_done};
  wire [2:0] clr = wr_istat ? wd[2:0] : 3'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl <= 7'h00;
      mode_bit0 <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      ctl <= {ctl_w[`CTL_MODE1:`CTL_TX9], next_rx_bit9, next_tx_flag, next_rx_flag};
      if (wr_ctrl && !fes) mode_bit0 <= wd[`CTL_TOP];
      frame_err <= set_frame_err | ((wr_ctrl && fes) ? wd[`CTL_TOP] : frame_err);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slv_addr <= `RST_BYTE;
      slv_mask <= `RST_BYTE;
      fes <= 1'b0;
      dbl <= 1'b0;
      baud <= `RST_BAUD;
      rx_buf <= `RST_BYTE;
    end else begin
      if (wr_slv_addr) slv_addr <= wd;
      if (wr_slv_mask) slv_mask <= wd;
      if (wr_pwr) fes <= wd[`PWR_FES];
      if (wr_pwr) dbl <= wd[`PWR_DBL];
      if (wr_baud) baud <= hwdata[15:0];
      if (set_rx_flag) rx_buf <= rx_byte;
    end
  end

  // ==========
  // Interrupts and pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat <= 3'h0;
      imask <= 3'h0;
      irq <= 1'b0;
      txd <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe_n <= 1'b1;
    end else begin
      istat <= ev | (istat & ~clr);
      if (wr_imask) imask <= wd[2:0];
      irq <= |(istat & imask);
      txd <= (rx_state == uart_pkg::RX_SHIFT) ? rx_sclk : txc.line;
      rxd_out <= txc.dout;
      rxd_oe_n <= txc.doe_n;
    end
  end

  // ==========
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_ERR_SET: assert property (set_frame_err |=> frame_err)
    else $error("frame error flag not set");
  AST_TOP_VIEW: assert property (fes && wr_ctrl |=> mode_bit0 == $past(mode_bit0))
    else $error("mode bit 0 changed while top bit is error flag");
  AST_ERR_STICKY: assert property (frame_err && !(wr_ctrl && fes) |=> frame_err)
    else $error("frame error flag dropped without software");
  AST_NO_FILTER: assert property (rx_fin && !match_en |=> rx_flag)
    else $error("frame lost with filtering off");
  AST_NINE_GATE: assert property (
    rx_fin && match_en && nine && !rx_ninth && !rx_flag && !wr_ctrl |=> !rx_flag)
    else $error("data byte passed address filter");
  AST_EIGHT_GATE: assert property (
    rx_fin && match_en && m8 && !(rx_stop && match) && !rx_flag && !wr_ctrl |=> !rx_flag)
    else $error("eight-bit frame passed filter");
  AST_SHIFT_IGNORE: assert property (rx_fin && m0 |=> rx_flag)
    else $error("shift mode receive not flagged");
  AST_RX9_STOP: assert property (rx_fin && m8 && !match_en |=> rx_bit9 == $past(rx_stop))
    else $error("stop bit not captured");
  AST_TXF_SET: assert property (tx_done |=> tx_flag)
    else $error("transmit done flag not set");
  AST_RXF_MID: assert property (
    rx_state == uart_pkg::RX_STOP && rx_tick && ren && !match_en |=> ##1 rx_flag)
    else $error("receive done not set mid stop");
  AST_REN_OFF: assert property (!ren |=> rx_state == uart_pkg::RX_IDLE)
    else $error("receiver active while disabled");

  CV_ERR: cover property (set_frame_err);
  CV_ADDR: cover property (rx_fin && match_en && match && set_rx_flag);
  CV_TX: cover property (tx_done && !m0);
  CV_SHIFT: cover property (rx_fin && m0);
endmodule : uart_frame_check_addr_match

// ### testbench/link_node.sv
/*
  Far-side serial node: sends asynchronous frames onto the receive pin
  and decodes frames seen on the transmit pin.
  Assumes one clock shared with the bench; the line idles high between frames.
*/
`timescale 1ns/1ps
module link_node (
  input wire logic hclk,
  input wire logic txd,
  output logic line
);
  initial line = 1'b1;
  // ==========
  // Sender: start, data LSB first, stop, then idle high
  task automatic send(input logic [8:0] bits, input int nbits, input logic stop, input int per);
    int i;
    @(posedge hclk);
    line <= 1'b0;
    repeat (per) @(posedge hclk);
    for (i = 0; i < nbits; i++) begin
      line <= bits[i];
      repeat (per) @(posedge hclk);
    end
    line <= stop;
    repeat (per) @(posedge hclk);
    line <= 1'b1;
  endtask : send
  // ==========
  // Receiver: samples each bit in its middle
  task automatic recv(input int per, output logic [7:0] b, output logic stop);
    int i;
    @(negedge txd);
    repeat (per / 2) @(posedge hclk);
    for (i = 0; i < 8; i++) begin
      repeat (per) @(posedge hclk);
      b[i] = txd;
    end
    repeat (per) @(posedge hclk);
    stop = txd;
  endtask : recv
  // Static level, used while the port shifts in mode 0
  task automatic hold(input logic v);
    @(posedge hclk);
    line <= v;
  endtask : hold
endmodule : link_node

// ### testbench/uart_frame_check_addr_match_tb.sv
/*
  Self-checking bench of the serial port: register bus, receive gating,
  frame error flag, address recognition, shift mode and transmit.
  Assumes the link_node far-side model and the register map of uart_cfg.svh.
*/
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_frame_check_addr_match_tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic rxd_in, rxd_out, rxd_oe_n, txd, irq;
  int err_count, total_checks;
  assign hready = hreadyout;
  uart_frame_check_addr_match i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd(txd), .irq(irq));
  link_node i_node (.hclk(hclk), .txd(txd), .line(rxd_in));
  // ==========
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic bus(input logic is_wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h000000, idx, 2'h0};
    hwrite <= is_wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic reg_wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, idx, wd, d);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] idx, output logic [31:0] d);
    bus(1'b0, idx, 32'h00000000, d);
  endtask : reg_rd
  task automatic chk_reg(input string name, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    reg_rd(idx, d);
    check(name, d, exp);
  endtask : chk_reg
  task automatic frame(input logic [8:0] bits, input int nbits, input logic stop, input int per);
    i_node.send(bits, nbits, stop, per);
    repeat (8) @(posedge hclk);
  endtask : frame
  // ==========
  // Scenarios
  task automatic test_reset();
    chk_reg("ctrl", `IDX_CTRL, 32'h00000000);
    chk_reg("slv_addr", `IDX_SLV_ADDR, 32'h00000000);
    chk_reg("slv_mask", `IDX_SLV_MASK, 32'h00000000);
    check("hresp", {31'h0, hresp}, 32'h00000000);
    check("txd_idle", {31'h0, txd}, 32'h00000001);
    check("out_idle", {31'h0, rxd_out}, 32'h00000001);
    chk_reg("baud", `IDX_BAUD, 32'h00000064);
    reg_wr(8'h10, 32'h000000FF);
    chk_reg("unmapped", 8'h10, 32'h00000000);
    check("irq", {31'h0, irq}, 32'h00000000);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_rx8();
    reg_wr(`IDX_BAUD, 32'h00000008);
    reg_wr(`IDX_CTRL, 32'h00000040);
    frame(9'h0A5, 8, 1'b1, 8);
    chk_reg("ctrl_no_ren", `IDX_CTRL, 32'h00000040);
    reg_wr(`IDX_CTRL, 32'h00000050);
    frame(9'h0A5, 8, 1'b1, 8);
    chk_reg("ctrl_rx", `IDX_CTRL, 32'h00000055);
    chk_reg("data", `IDX_DATA, 32'h000000A5);
    chk_reg("istat", `IDX_ISTAT, 32'h00000002);
    check("irq_masked", {31'h0, irq}, 32'h00000000);
    reg_wr(`IDX_IMASK, 32'h00000002);
    repeat (2) @(posedge hclk);
    check("irq_on", {31'h0, irq}, 32'h00000001);
    reg_wr(`IDX_ISTAT, 32'h00000002);
    repeat (2) @(posedge hclk);
    check("irq_off", {31'h0, irq}, 32'h00000000);
    chk_reg("istat_clr", `IDX_ISTAT, 32'h00000000);
    $display("test_rx8 done");
  endtask : test_rx8
  task automatic test_frame_error();
    reg_wr(`IDX_CTRL, 32'h00000050);
    frame(9'h03C, 8, 1'b0, 8);
    reg_rd(`IDX_CTRL, v);
    check("bit7_mode", {31'h0, v[7]}, 32'h00000000);
    chk_reg("istat_fe", `IDX_ISTAT, 32'h00000006);
    reg_wr(`IDX_PWR, 32'h00000040);
    reg_rd(`IDX_CTRL, v);
    check("bit7_flag", {31'h0, v[7]}, 32'h00000001);
    frame(9'h0C3, 8, 1'b1, 8);
    reg_rd(`IDX_CTRL, v);
    check("flag_sticky", {31'h0, v[7]}, 32'h00000001);
    reg_wr(`IDX_CTRL, 32'h00000050);
    reg_rd(`IDX_CTRL, v);
    check("flag_clr", {31'h0, v[7]}, 32'h00000000);
    reg_wr(`IDX_PWR, 32'h00000000);
    reg_wr(`IDX_ISTAT, 32'h00000007);
    $display("test_frame_error done");
  endtask : test_frame_error
  task automatic test_match8();
    logic [8:0] fr [3] = '{9'h0C0, 9'h0C1, 9'h0C0};
    logic [2:0] stp = 3'b011;
    logic [2:0] ok = 3'b001;
    int i;
    reg_wr(`IDX_CTRL, 32'h00000070);
    frame(9'h037, 8, 1'b1, 8);
    chk_reg("rxf_reset_addr", `IDX_CTRL, 32'h00000075);
    reg_wr(`IDX_SLV_ADDR, 32'h000000C0);
    reg_wr(`IDX_SLV_MASK, 32'h000000FD);
    for (i = 0; i < 3; i++) begin
      reg_wr(`IDX_CTRL, 32'h00000070);
      frame(fr[i], 8, stp[i], 8);
      reg_rd(`IDX_CTRL, v);
      check("rxf_mode1", {31'h0, v[0]}, {31'h0, ok[i]});
    end
    $display("test_match8 done");
  endtask : test_match8
  task automatic test_match9();
    logic [8:0] fr [6] = '{9'h1C2, 9'h1C0, 9'h1C1, 9'h0C0, 9'h1FD, 9'h17D};
    logic [5:0] ok = 6'b010011;
    int i;
    for (i = 0; i < 6; i++) begin
      reg_wr(`IDX_CTRL, 32'h000000F0);
      frame(fr[i], 9, 1'b1, 8);
      reg_rd(`IDX_CTRL, v);
      check("rxf_mode3", {31'h0, v[0]}, {31'h0, ok[i]});
      check("rx_bit9", {31'h0, v[2]}, {31'h0, ok[i]});
    end
    reg_wr(`IDX_CTRL, 32'h000000B0);
    frame(9'h1C2, 9, 1'b1, 32);
    chk_reg("rxf_mode2", `IDX_CTRL, 32'h000000B5);
    reg_wr(`IDX_CTRL, 32'h000000D0);
    frame(9'h0C1, 9, 1'b1, 8);
    chk_reg("rxf_no_match", `IDX_CTRL, 32'h000000D1);
    $display("test_match9 done");
  endtask : test_match9
  task automatic test_shift();
    // Enter shift mode with receive off, so the low pin starts no async frame
    reg_wr(`IDX_CTRL, 32'h00000020);
    i_node.hold(1'b0);
    reg_wr(`IDX_CTRL, 32'h00000030);
    repeat (80) @(posedge hclk);
    i_node.hold(1'b1);
    reg_rd(`IDX_CTRL, v);
    check("rxf_mode0", {31'h0, v[0]}, 32'h00000001);
    chk_reg("data_mode0", `IDX_DATA, 32'h00000000);
    reg_wr(`IDX_DATA, 32'h00000000);
    repeat (8) @(posedge hclk);
    check("oe_mode0", {31'h0, rxd_oe_n}, 32'h00000000);
    check("out_mode0", {31'h0, rxd_out}, 32'h00000000);
    repeat (60) @(posedge hclk);
    check("oe_end_mode0", {31'h0, rxd_oe_n}, 32'h00000001);
    reg_rd(`IDX_CTRL, v);
    check("txf_mode0", {31'h0, v[1]}, 32'h00000001);
    reg_wr(`IDX_CTRL, 32'h00000000);
    $display("test_shift done");
  endtask : test_shift
  task automatic test_tx();
    logic [7:0] b;
    logic s;
    reg_wr(`IDX_CTRL, 32'h00000050);
    reg_wr(`IDX_ISTAT, 32'h00000007);
    fork
      reg_wr(`IDX_DATA, 32'h0000005A);
      i_node.recv(8, b, s);
    join
    check("tx_byte", {24'h0, b}, 32'h0000005A);
    check("tx_stop", {31'h0, s}, 32'h00000001);
    reg_rd(`IDX_CTRL, v);
    check("txf", {31'h0, v[1]}, 32'h00000001);
    chk_reg("istat_tx", `IDX_ISTAT, 32'h00000001);
    $display("test_tx done");
  endtask : test_tx
  // ==========
  // Verdict
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    repeat (40000) @(posedge hclk);
    err_count++;
    finish_test();
  end
  initial begin
    err_count = 0;
    total_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = `HSIZE_WORD;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset();
    test_rx8();
    test_frame_error();
    test_match8();
    test_match9();
    test_shift();
    test_tx();
    finish_test();
  end
endmodule : uart_frame_check_addr_match_tb
